// ===== hw/crc8_reflected.sv
/*
  One byte step of the reflected 8-bit checksum.
  Assumes a purely combinational use; the caller holds the running value.
*/
`timescale 1ns/100ps
`include "spi_host_cfg.svh"

module crc8_reflected (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] crc_out
);

  logic [7:0] poly_rev;

  // Reflected polynomial, LSB-first update
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    poly_rev = {<<{8'(`CRC_POLY)}}; // RULE_13
    c = crc_in ^ byte_in; // RULE_14
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ poly_rev;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end

endmodule

// ===== hw/spi_host.sv
/*
  Host side of the serial register port: frames 32- or 40-bit transactions,
  appends the write checksum and checks the read checksum.
  Assumes the device samples MOSI on the rising SCLK edge and shifts MISO on
  the falling edge (mode 0); MISO arrives from outside and is synchronised.
*/
`timescale 1ns/100ps
`include "spi_host_cfg.svh"

module spi_host (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CRC_EN,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire spi_host_pkg::cmd_type REQ_CMD,
  output logic RSP_VALID,
  output spi_host_pkg::rsp_type RSP,
  output logic SCLK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO
);

  // ****************************************
  // Input synchroniser and checksum helpers
  // ****************************************
  logic miso_s1_r, miso_s2_r, miso_s3_r, miso_val_r;
  logic miso_val_nxt;

  always_comb begin
    miso_val_nxt = miso_val_r;
    if (miso_s2_r == miso_s3_r) begin
      miso_val_nxt = miso_s3_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      miso_s3_r <= 1'b0;
      miso_val_r <= 1'b0;
    end else begin
      miso_s1_r <= MISO;
      miso_s2_r <= miso_s1_r;
      miso_s3_r <= miso_s2_r;
      miso_val_r <= miso_val_nxt;
    end
  end

  // Checksum over four bytes, chained; the LSB-first step does the reflection
  logic [31:0] crc_src;
  logic [7:0] crc_chain [0:4];
  logic [7:0] crc_result;
  assign crc_chain[0] = 8'(`CRC_INIT);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_crc
      crc8_reflected u_step (
        .crc_in(crc_chain[g]),
        .byte_in(crc_src[31-8*g -: 8]),
        .crc_out(crc_chain[g+1])
      );
    end
  endgenerate
  assign crc_result = crc_chain[4] ^ 8'(`CRC_XOR_OUT); // RULE_14 RULE_15

  // ****************************************
  // Frame sequencer
  // ****************************************
  spi_host_pkg::state_type state_r, state_nxt;
  logic [39:0] tx_r, tx_nxt;
  logic [39:0] rx_r, rx_nxt;
  logic [5:0] bits_r, bits_nxt;
  logic [5:0] len_r, len_nxt;
  logic [3:0] tim_r, tim_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_n_r, cs_n_nxt;
  logic crc_on_r, crc_on_nxt;
  logic read_r, read_nxt;
  logic rsp_v_r, rsp_v_nxt;
  spi_host_pkg::rsp_type rsp_r, rsp_nxt;
  logic [7:0] rsp_crc;

  assign crc_src = (state_r == spi_host_pkg::ST_IDLE) ? {REQ_CMD.addr, REQ_CMD.read, REQ_CMD.data} : rx_r[39:8];
  assign rsp_crc = rx_r[7:0];

  always_comb begin
    state_nxt = state_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    bits_nxt = bits_r;
    len_nxt = len_r;
    tim_nxt = tim_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    crc_on_nxt = crc_on_r;
    read_nxt = read_r;
    rsp_v_nxt = 1'b0;
    rsp_nxt = rsp_r;
    case (state_r)
      spi_host_pkg::ST_IDLE: begin
        if (REQ_VALID) begin
          crc_on_nxt = CRC_EN; // RULE_04
          read_nxt = REQ_CMD.read;
          tx_nxt = {REQ_CMD.addr, REQ_CMD.read, REQ_CMD.data, 8'h00}; // RULE_10 RULE_11 RULE_12
          if (CRC_EN && !REQ_CMD.read) begin
            tx_nxt[7:0] = crc_result; // RULE_05
          end
          len_nxt = CRC_EN ? 6'(`FRAME_BITS_CRC) : 6'(`FRAME_BITS_PLAIN); // RULE_01 RULE_02
          bits_nxt = 6'h00;
          rx_nxt = 40'h00_0000_0000;
          tim_nxt = 4'(`SCLK_HALF_CYC - 1);
          cs_n_nxt = 1'b0; // RULE_18
          state_nxt = spi_host_pkg::ST_SHIFT;
        end
      end
      spi_host_pkg::ST_SHIFT: begin
        if (tim_r != 4'h0) begin
          tim_nxt = tim_r - 4'h1;
        end else begin
          tim_nxt = 4'(`SCLK_HALF_CYC - 1);
          if (!sclk_r) begin
            sclk_nxt = 1'b1;
            rx_nxt = {rx_r[38:0], miso_val_r}; // RULE_18
            bits_nxt = bits_r + 6'h01;
          end else begin
            sclk_nxt = 1'b0;
            tx_nxt = {tx_r[38:0], 1'b0};
            if (bits_r == len_r) begin
              cs_n_nxt = 1'b1;
              tim_nxt = 4'(`CS_GAP_CYC - 1);
              rsp_v_nxt = 1'b1;
              state_nxt = spi_host_pkg::ST_GAP;
              if (len_r == 6'(`FRAME_BITS_PLAIN)) begin
                rsp_nxt.data = rx_r[23:0];
                rsp_nxt.crc_bad = 1'b0;
              end else begin
                rsp_nxt.data = rx_r[31:8];
                rsp_nxt.crc_bad = read_r && (rsp_crc != crc_result); // RULE_09 RULE_08
              end
            end
          end
        end
      end
      spi_host_pkg::ST_GAP: begin
        if (tim_r != 4'h0) begin
          tim_nxt = tim_r - 4'h1;
        end else begin
          state_nxt = spi_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = spi_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= spi_host_pkg::ST_IDLE;
      tx_r <= 40'h00_0000_0000;
      rx_r <= 40'h00_0000_0000;
      bits_r <= 6'h00;
      len_r <= 6'h20;
      tim_r <= 4'h0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      crc_on_r <= 1'b0;
      read_r <= 1'b0;
      rsp_v_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      state_r <= state_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      bits_r <= bits_nxt;
      len_r <= len_nxt;
      tim_r <= tim_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      crc_on_r <= crc_on_nxt;
      read_r <= read_nxt;
      rsp_v_r <= rsp_v_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign REQ_READY = (state_r == spi_host_pkg::ST_IDLE);
  assign SCLK = sclk_r;
  assign CS_N = cs_n_r;
  assign MOSI = tx_r[39];
  assign RSP_VALID = rsp_v_r;
  assign RSP = rsp_r;

  // ****************************************
  // Assertions and cover points
  // ****************************************
  int unsigned edge_cnt;
  always_ff @(posedge CLK) begin
    if (RESET || cs_n_r) begin
      edge_cnt <= 0;
    end else if (sclk_r && !sclk_nxt) begin
      edge_cnt <= edge_cnt + 1;
    end
  end

  a_plain_len: assert property (@(posedge CLK) disable iff (RESET) // RULE_01
    $rose(cs_n_r) && !crc_on_r |-> edge_cnt == 32) else $error("plain frame not 32 clocks");
  a_crc_len: assert property (@(posedge CLK) disable iff (RESET) // RULE_02
    $rose(cs_n_r) && crc_on_r |-> edge_cnt == 40) else $error("checksum frame not 40 clocks");
  a_cs_frame: assert property (@(posedge CLK) disable iff (RESET) // RULE_18
    $fell(cs_n_r) |-> !sclk_r throughout (state_r == spi_host_pkg::ST_SHIFT)[*2]) else $error("clock high at select");
  a_sclk_idle: assert property (@(posedge CLK) disable iff (RESET) // RULE_18
    cs_n_r |-> !sclk_r) else $error("clock toggles outside frame");
  a_addr_first: assert property (@(posedge CLK) disable iff (RESET) // RULE_11
    REQ_VALID && REQ_READY |=> MOSI == $past(REQ_CMD.addr[6])) else $error("address not first");
  a_wr_crc: assert property (@(posedge CLK) disable iff (RESET) // RULE_05
    REQ_VALID && REQ_READY && CRC_EN && !REQ_CMD.read |=> tx_r[7:0] == $past(crc_result)) else $error("write checksum wrong");
  a_rd_nocrc: assert property (@(posedge CLK) disable iff (RESET) // RULE_07
    REQ_VALID && REQ_READY && REQ_CMD.read |=> tx_r[7:0] == 8'h00) else $error("read tail not zero");
  a_rsp_once: assert property (@(posedge CLK) disable iff (RESET) // RULE_09
    RSP_VALID |=> !RSP_VALID ##0 cs_n_r) else $error("response not single pulse");

  c_plain_write: cover property (@(posedge CLK) REQ_VALID && REQ_READY && !CRC_EN && !REQ_CMD.read);
  c_crc_write: cover property (@(posedge CLK) REQ_VALID && REQ_READY && CRC_EN && !REQ_CMD.read);
  c_crc_read: cover property (@(posedge CLK) REQ_VALID && REQ_READY && CRC_EN && REQ_CMD.read);
  c_bad_crc: cover property (@(posedge CLK) RSP_VALID && RSP.crc_bad);

endmodule

// ===== hw/spi_host_cfg.svh
/*
  Constants of the serial register port host: frame layout, checksum, timing.
  Assumes inclusion by the design modules of the host; the package does not include it.
*/
// Behaviour
// RULE_01 - Checksum off: each transaction is four bytes under one select.
// RULE_02 - Checksum on: every read or write transaction is five bytes.
// RULE_03 - Device starts with checksum off; software reset keeps the setting.
// RULE_04 - Checksum enable changes any time and covers reads and writes.
// RULE_05 - Host appends correct checksum over the four bytes of a write.
// RULE_06 - Device recomputes write checksum and flags an error on mismatch.
// RULE_07 - Device ignores host final byte on reads and does not verify.
// RULE_08 - Device returns checksum over command byte and three data bytes.
// RULE_09 - Host verifies the checksum returned on reads.
// RULE_10 - Command is 7-bit address, direction bit, 24-bit payload.
// RULE_11 - 32-bit frame: address 31:25, direction 24, payload 23:0.
// RULE_12 - 40-bit frame: address 39:33, direction 32, payload 31:8, checksum 7:0.
// RULE_13 - Checksum is 8-bit cyclic code, polynomial x^8+x^5+x^4+1.
// RULE_14 - Checksum starts at zero, no final inversion, reflected in and out.
// RULE_15 - Checksum covers exactly the 32 bits of the plain frame.
// RULE_16 - Device exposes a readable 32-bit per-part tracking number.
// RULE_17 - Port held in reset until power-on reset releases.
// RULE_18 - Bits go most significant first, one active-low select per transaction.
// RULE_19 - Failed-checksum write leaves register unchanged; error flag stays set.
`ifndef SPI_HOST_CFG_SVH
`define SPI_HOST_CFG_SVH

`define FRAME_BITS_PLAIN 6'h20
`define FRAME_BITS_CRC 6'h28
`define CRC_POLY 8'h31
`define CRC_INIT 8'h00
`define CRC_XOR_OUT 8'h00
`define CLK_PERIOD_NS 10
// Half period outlasts the four-cycle MISO synchroniser delay
`define SCLK_HALF_NS 50
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_GAP_NS 50
`define CS_GAP_CYC ((`CS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/spi_host_pkg.sv
/*
  Types of the serial register port host.
  Assumes spi_host_cfg.svh is on the include path.
*/
package spi_host_pkg;

  typedef struct packed {
    logic [6:0] addr;
    logic read;
    logic [23:0] data;
  } cmd_type;

  typedef struct packed {
    logic [23:0] data;
    logic crc_bad;
  } rsp_type;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} state_type;

endpackage

// ===== tb/dev_crc_pkg.sv
/*
  Reflected 8-bit checksum, poly 0x31, for the bench side.
  Assumes bytes are taken most significant byte first.
*/
package dev_crc_pkg;
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      c = c ^ d[i*8 +: 8];
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 8'h8C) : (c >> 1);
      end
    end
    return c;
  endfunction
endpackage

// ===== tb/dev_model.sv
/*
  Behavioural model of the serial register device.
  Assumes mode 0 framing and a host clock that idles low.
*/
`timescale 1ns/100ps

module dev_model #(
  parameter logic [6:0] CTRL_ADDR = 7'h7D,
  parameter logic [6:0] TRACK_ADDR = 7'h7E,
  parameter logic [31:0] TRACK_NUM = 32'h1234_5678 // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic corrupt,
  output logic miso
);
  logic [23:0] mem [128];
  logic [39:0] rx = 40'h00;
  logic [31:0] tx;
  logic [31:0] cmd;
  logic [31:0] fin;
  logic [5:0] n = 6'h00;
  logic echo = 1'b0;
  logic prev = 1'b0;
  logic crc_on = 1'b0;
  logic crc_err = 1'b0;
  // Command byte echoed, then data and checksum; released line inverted
  assign miso = cs_n ? ~prev : (echo ? mosi : tx[31]);
  always @(posedge clk) begin
    if (reset) begin
      crc_on = 1'b0;
      crc_err = 1'b0;
    end
  end
  always @(negedge cs_n) begin
    n = 6'h00;
    echo = 1'b1;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      rx = {rx[38:0], mosi ^ (corrupt && n == 6'h1F)};
      n = n + 6'h01;
      if (n == 6'h08) begin
        cmd[31:24] = rx[7:0];
        cmd[23:0] = mem[rx[7:1]];
        if (rx[7:1] == TRACK_ADDR) cmd[23:0] = TRACK_NUM[31:8];
        if (rx[7:1] == TRACK_ADDR + 7'h01) cmd[23:0] = {16'h0000, TRACK_NUM[7:0]};
        tx = {cmd[23:0], dev_crc_pkg::crc8(cmd) ^ {7'h00, corrupt}};
      end
    end
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      prev = miso;
      if (echo && n == 6'h08) echo = 1'b0;
      else if (!echo) tx = {tx[30:0], 1'b0};
    end
  end
  // Frame end: reads need no check, writes checked when enabled
  always @(posedge cs_n) begin
    fin = crc_on ? rx[39:8] : rx[31:0];
    if (n != 6'h00 && n == (crc_on ? 6'h28 : 6'h20) && !fin[24]) begin
      if (crc_on && rx[7:0] != dev_crc_pkg::crc8(fin)) crc_err = 1'b1;
      else begin
        mem[fin[31:25]] = fin[23:0];
        if (fin[31:25] == CTRL_ADDR) crc_on = fin[0];
        if (fin[31:25] == CTRL_ADDR && fin[1]) crc_err = 1'b0;
      end
    end
  end
endmodule

// ===== tb/spi_register_port_with_crc8_tb_top.sv
/*
  Self-checking bench of the serial port host against the device model.
  Assumes the host package and config header on the include path.
*/
`timescale 1ns/100ps

module spi_register_port_with_crc8_tb_top;
  localparam logic [6:0] ctrl = 7'h7D;
  localparam logic [6:0] track = 7'h7E;
  localparam logic [31:0] track_num = 32'hC0DE_0042;
  logic clk, reset, crc_en, req_valid, req_ready, rsp_valid, sclk, cs_n, mosi, miso, corrupt;
  spi_host_pkg::cmd_type req_cmd;
  spi_host_pkg::rsp_type rsp, got;
  int fail_count = 0;
  int checks = 0;
  spi_host DUT (.CLK(clk), .RESET(reset), .CRC_EN(crc_en), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_CMD(req_cmd), .RSP_VALID(rsp_valid), .RSP(rsp), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso));
  dev_model #(.CTRL_ADDR(ctrl), .TRACK_ADDR(track), .TRACK_NUM(track_num)) dev (.clk(clk), .reset(reset),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .corrupt(corrupt), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] seen);
    checks++;
    if (exp !== seen) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [23:0] d, input logic ce);
    int k;
    k = 0;
    @(posedge clk);
    req_cmd <= {a, rd, d};
    crc_en <= ce;
    req_valid <= 1'b1;
    #1;
    while (!req_ready && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (!rsp_valid && k < 1000);
    if (!rsp_valid) begin
      fail_count++;
      stop_test();
    end
    got = rsp;
    check("frame bits", ce ? 40'h28 : 40'h20, {34'h0, dev.n});
  endtask
  task automatic t_plain;
    @(posedge clk);
    #1;
    check("idle select", 1'b1, cs_n);
    check("write crc", 8'h11, dev_crc_pkg::crc8(32'h06000F00));
    check("read crc", 8'hCB, dev_crc_pkg::crc8(32'h05100000));
    xfer(7'h12, 1'b0, 24'hA5C3F0, 1'b0);
    check("frame", 32'h24A5C3F0, dev.rx[31:0]);
    xfer(7'h12, 1'b1, 24'h000000, 1'b0);
    check("read data", 24'hA5C3F0, got.data);
  endtask
  task automatic t_crc;
    logic [23:0] hi;
    xfer(ctrl, 1'b0, 24'h000001, 1'b0);
    check("crc on", 1'b1, dev.crc_on);
    xfer(7'h03, 1'b0, 24'h000F00, 1'b1);
    check("crc frame", 40'h06000F0011, dev.rx);
    check("crc error", 1'b0, dev.crc_err);
    xfer(7'h02, 1'b0, 24'h100000, 1'b1);
    xfer(7'h02, 1'b1, 24'hFFFFFF, 1'b1);
    check("read data", 24'h100000, got.data);
    check("crc flag", 1'b0, got.crc_bad);
    check("tail byte", 8'h00, dev.rx[7:0]);
    xfer(track, 1'b1, 24'h000000, 1'b1);
    hi = got.data;
    xfer(track + 7'h01, 1'b1, 24'h000000, 1'b1);
    check("tracking", track_num, {hi, got.data[7:0]});
  endtask
  task automatic t_fault;
    @(posedge clk);
    corrupt <= 1'b1;
    xfer(7'h02, 1'b0, 24'h0000FF, 1'b1);
    check("crc error", 1'b1, dev.crc_err);
    check("kept word", 24'h100000, dev.mem[2]);
    xfer(7'h02, 1'b1, 24'h000000, 1'b1);
    check("crc flag", 1'b1, got.crc_bad);
    @(posedge clk);
    corrupt <= 1'b0;
    xfer(7'h02, 1'b1, 24'h000000, 1'b1);
    check("error held", 1'b1, dev.crc_err);
    xfer(ctrl, 1'b0, 24'h000002, 1'b1);
    check("error clear", 1'b0, dev.crc_err);
    xfer(7'h02, 1'b1, 24'h000000, 1'b0);
    check("plain read", 24'h100000, got.data);
  endtask
  task automatic t_reset;
    xfer(ctrl, 1'b0, 24'h000001, 1'b0);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check("crc off", 1'b0, dev.crc_on);
    xfer(7'h12, 1'b1, 24'h000000, 1'b0);
    check("read after reset", 24'hA5C3F0, got.data);
  endtask
  initial begin
    reset = 1'b1;
    crc_en = 1'b0;
    req_valid = 1'b0;
    req_cmd = '0;
    corrupt = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_plain();
    t_crc();
    t_fault();
    t_reset();
    stop_test();
  end
endmodule
